// ### include/pbcs_cfg.svh
// Purpose: constants of the polling and bit check sequencer
// Assumes: included by bare name from design files
// Notes: offsets are APB byte addresses, one 32-bit word each
// Summary of operation
// [RULE1] poll loops dormant, settling, checking, in order
// [RULE2] dormant keeps signal processing off whole period
// [RULE3] settling enables processing, waits before checking
// [RULE4] failed check returns to dormant phase
// [RULE5] dormant period is count times factor times 1024
// [RULE6] factor eight when either stretch bit set
// [RULE7] persistent stretch bit always stretches dormant period
// [RULE8] temporary stretch bit self-clears on failed check
// [RULE9] highest dormant count means permanent dormancy
// [RULE10] bit setting gives 0, 6, 12, 18 checks
// [RULE11] interval inside window continues, otherwise abort
// [RULE12] window limits: lower count, upper count minus one; code also passes an interval of exactly the upper count
// [RULE13] software keeps lower >= 10, upper <= 63
// [RULE14] window counts reset to 14 and 24
// [RULE15] demodulator ignored settling; counter per extended tick
// [RULE16] fail below lower at edge, or reaching upper
// [RULE17] all checks passed enters receiving, forwards data
// [RULE18] extended tick is 8, 4, 2, 1 base ticks
// [RULE19] receiving holds until software returns to polling
// [RULE20] counter restarts each edge; first edge unchecked
// [RULE21] zero bit count enters receiving after settling
`ifndef PBCS_CFG_SVH
`define PBCS_CFG_SVH
// register byte offsets
`define PBCS_OFF_OPC       12'h000
`define PBCS_OFF_LIM       12'h004
`define PBCS_OFF_STAT      12'h008
`define PBCS_OFF_CTRL      12'h00C
// operating configuration field positions
`define PBCS_OPC_BAUD_POS  0
`define PBCS_OPC_NBIT_POS  2
`define PBCS_OPC_SLEEP_POS 4
`define PBCS_OPC_XSTD_POS  9
`define PBCS_OPC_XTMP_POS  10
// window limit field positions
`define PBCS_LIM_MIN_POS   0
`define PBCS_LIM_MAX_POS   8
// status field positions
`define PBCS_ST_PHASE_POS  0
`define PBCS_ST_XTMP_POS   2
`define PBCS_ST_CHK_POS    4
// control bit position
`define PBCS_CTRL_RET_POS  0
// reset values
`define PBCS_RST_BAUD      2'h0
`define PBCS_RST_NBIT      2'h2
`define PBCS_RST_SLEEP     5'h0B
`define PBCS_RST_LIM_MIN   6'h0E
`define PBCS_RST_LIM_MAX   6'h18
// dormant count value meaning permanent dormancy
`define PBCS_SLEEP_PERM    5'h1F
// timing: base tick period and system clock period in ns
`define PBCS_TCLK_NS       2040
`define PBCS_CLK_NS        8
`define PBCS_BASE_DIV      ((`PBCS_TCLK_NS) / (`PBCS_CLK_NS))
// settling length in extended ticks
`define PBCS_SETTLE_XT     16
`endif

// ### include/pbcs_pkg.sv
// Purpose: types of the polling and bit check sequencer
// Assumes: nothing
// Notes: APB carried as request and response structs
package pbcs_pkg;
    typedef enum logic [1:0] {
        PH_DORM   = 2'b00,
        PH_SETTLE = 2'b01,
        PH_CHECK  = 2'b10,
        PH_RX     = 2'b11
    } pbcs_phase_e;

    typedef struct packed {
        logic       xtemp;
        logic       xstd;
        logic [4:0] sleep;
        logic [1:0] nbit;
        logic [1:0] baud;
    } pbcs_opcfg_s;

    typedef struct packed {
        logic [5:0] lim_max;
        logic [5:0] lim_min;
    } pbcs_lim_s;

    typedef struct packed {
        logic [11:0] paddr;
        logic        pwrite;
        logic [31:0] pwdata;
        logic        psel;
        logic        penable;
    } pbcs_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } pbcs_apb_rsp_s;

    typedef struct packed {
        pbcs_phase_e phase;
        pbcs_opcfg_s opc;
        pbcs_lim_s   lim;
        logic [17:0] slp_cnt;
        logic [7:0]  set_cnt;
        logic [5:0]  iv_cnt;
        logic [4:0]  chk_cnt;
        logic        armed;
        logic        prev;
        logic        data;
        logic [31:0] rdata;
    } pbcs_top_s;
endpackage : pbcs_pkg

// ### logic/pbcs_sync.sv
// Purpose: two-stage synchroniser, also used as reset release
// Assumes: rst_n asynchronous, active low
// Notes: first stage feeds only the second stage
`timescale 1ns/100ps
module pbcs_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic clk,
    input  wire logic ce,
    input  wire logic rst_n,
    input  wire logic d,
    output logic      q
);
    typedef struct packed {
        logic ff2;
        logic ff1;
    } pbcs_sync_s;

    pbcs_sync_s s_r;
    pbcs_sync_s s_nxt;

    // shift the sampled level through two stages
    always_comb begin
        s_nxt = s_r;
        if (ce) begin
            s_nxt.ff1 = d;
            s_nxt.ff2 = s_r.ff1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= {RESET_VAL, RESET_VAL};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign q = s_r.ff2;
endmodule : pbcs_sync

// ### logic/pbcs_tick.sv
// Purpose: base tick prescaler and extended tick divider
// Assumes: band from the operating configuration
// Notes: both ticks are one-cycle pulses
`timescale 1ns/100ps
`include "pbcs_cfg.svh"
module pbcs_tick #(
    parameter int BASE_DIV = `PBCS_BASE_DIV
) (
    input  wire logic       clk,
    input  wire logic       ce,
    input  wire logic       rst_n,
    input  wire logic [1:0] band,
    output logic            base_tick,
    output logic            ext_tick
);
    typedef struct packed {
        logic [11:0] pre;
        logic [2:0]  ext;
    } pbcs_tick_s;

    pbcs_tick_s s_r;
    pbcs_tick_s s_nxt;
    logic [2:0] ext_last;

    // extended tick spans 8, 4, 2 or 1 base ticks
    assign ext_last  = 3'(4'h8 >> band) - 3'h1; // [RULE18]
    assign base_tick = ce && (s_r.pre == 12'(BASE_DIV - 1));
    assign ext_tick  = base_tick && (s_r.ext >= ext_last);

    // prescaler and extended divider counters
    always_comb begin
        s_nxt = s_r;
        if (ce) begin
            s_nxt.pre = base_tick ? 12'h000 : s_r.pre + 12'h001;
            if (ext_tick) begin
                s_nxt.ext = 3'h0;
            end else if (base_tick) begin
                s_nxt.ext = s_r.ext + 3'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule : pbcs_tick

// ### logic/pbcs_top.sv
// Purpose: polling and bit check sequencer with APB registers
// Assumes: demod_in asynchronous; APB on clk
// Notes: zero-wait APB slave, unmapped address answers pslverr
`timescale 1ns/100ps
`include "pbcs_cfg.svh"
module pbcs_top #(
    parameter int BASE_DIV  = `PBCS_BASE_DIV,
    parameter int SETTLE_XT = `PBCS_SETTLE_XT
) (
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    input  wire logic                   clk_en,
    input  wire pbcs_pkg::pbcs_apb_req_s apb_req,
    output pbcs_pkg::pbcs_apb_rsp_s      apb_rsp,
    input  wire logic                   demod_in,
    output logic                        data_out,
    output logic                        rx_active,
    output logic                        sig_proc_en
);
    pbcs_pkg::pbcs_top_s s_r;
    pbcs_pkg::pbcs_top_s s_nxt;

    logic        rst_n;
    logic        dm;
    logic        base_tick;
    logic        ext_tick;
    logic [17:0] slp_target;
    logic [4:0]  n_checks;
    logic        edge_seen;
    logic        low_fail;
    logic        high_fail;
    logic        wr_acc;
    logic        rd_setup;
    logic        mapped;
    logic        opc_wr;
    logic        lim_wr;
    logic        ret_wr;

    // dormant length in base ticks: count x factor x 1024
    function automatic logic [17:0] sleep_len(
        input logic [4:0] cnt,
        input logic       stretch
    );
        if (stretch) begin
            sleep_len = {cnt, 13'h0000}; // [RULE6]
        end else begin
            sleep_len = {3'h0, cnt, 10'h000};
        end
    endfunction : sleep_len

    // number of interval checks: bits x 6
    function automatic logic [4:0] check_count(input logic [1:0] nb);
        check_count = {1'b0, nb, 2'h0} + {2'h0, nb, 1'b0};
    endfunction : check_count

    // release reset through two flops
    pbcs_sync #(
        .RESET_VAL (1'b0)
    ) u_rst_sync (
        .clk   (clk),
        .ce    (1'b1),
        .rst_n (reset_n),
        .d     (1'b1),
        .q     (rst_n)
    );

    // demodulator level into the clock domain
    pbcs_sync #(
        .RESET_VAL (1'b0)
    ) u_dem_sync (
        .clk   (clk),
        .ce    (clk_en),
        .rst_n (rst_n),
        .d     (demod_in),
        .q     (dm)
    );

    // base and extended ticks
    pbcs_tick #(
        .BASE_DIV (BASE_DIV)
    ) u_tick (
        .clk       (clk),
        .ce        (clk_en),
        .rst_n     (rst_n),
        .band      (s_r.opc.baud),
        .base_tick (base_tick),
        .ext_tick  (ext_tick)
    );

    // apb decode
    assign mapped   = (apb_req.paddr == `PBCS_OFF_OPC)
                   || (apb_req.paddr == `PBCS_OFF_LIM)
                   || (apb_req.paddr == `PBCS_OFF_STAT)
                   || (apb_req.paddr == `PBCS_OFF_CTRL);
    assign wr_acc   = clk_en && apb_req.psel && apb_req.penable
                   && apb_req.pwrite && mapped;
    assign rd_setup = clk_en && apb_req.psel && !apb_req.penable;
    assign opc_wr   = wr_acc && (apb_req.paddr == `PBCS_OFF_OPC);
    assign lim_wr   = wr_acc && (apb_req.paddr == `PBCS_OFF_LIM);
    assign ret_wr   = wr_acc && (apb_req.paddr == `PBCS_OFF_CTRL)
                   && apb_req.pwdata[`PBCS_CTRL_RET_POS];

    // apb answer: always ready, error on unmapped access
    assign apb_rsp = '{prdata:  s_r.rdata,
                       pready:  1'b1,
                       pslverr: apb_req.psel && apb_req.penable && !mapped};

    // derived check quantities
    assign slp_target = sleep_len(s_r.opc.sleep,
                                  s_r.opc.xstd || s_r.opc.xtemp); // [RULE5] [RULE7]
    assign n_checks   = check_count(s_r.opc.nbit); // [RULE10]
    assign edge_seen  = ext_tick && (dm != s_r.prev);
    // counter lags the ticks since the edge by one, so compare its successor
    assign low_fail   = edge_seen && s_r.armed
                     && ((s_r.iv_cnt + 6'h01) < s_r.lim.lim_min); // [RULE16] [RULE12]
    assign high_fail  = ext_tick && !edge_seen
                     && ((s_r.iv_cnt + 6'h01) >= s_r.lim.lim_max); // [RULE16] [RULE12]

    // outputs
    assign data_out    = s_r.data;
    assign rx_active   = (s_r.phase == pbcs_pkg::PH_RX);
    assign sig_proc_en = (s_r.phase != pbcs_pkg::PH_DORM); // [RULE2] [RULE3]

    // sequencer and register file
    always_comb begin
        s_nxt = s_r;
        if (clk_en) begin
            case (s_r.phase)
                // dormant: count base ticks up to the period
                pbcs_pkg::PH_DORM: begin
                    if (s_r.opc.sleep == `PBCS_SLEEP_PERM) begin
                        s_nxt.slp_cnt = '0; // [RULE9]
                    end else if (s_r.slp_cnt >= slp_target) begin
                        s_nxt.phase   = pbcs_pkg::PH_SETTLE; // [RULE1] [RULE2]
                        s_nxt.set_cnt = '0;
                    end else if (base_tick) begin
                        s_nxt.slp_cnt = s_r.slp_cnt + 18'h00001;
                    end
                end
                // settling: demodulator output not looked at
                pbcs_pkg::PH_SETTLE: begin
                    if (ext_tick) begin
                        if (s_r.set_cnt == 8'(SETTLE_XT - 1)) begin // [RULE3] [RULE15]
                            s_nxt.iv_cnt  = '0;
                            s_nxt.chk_cnt = '0;
                            s_nxt.armed   = 1'b0;
                            s_nxt.prev    = dm;
                            if (n_checks == 5'h00) begin
                                s_nxt.phase = pbcs_pkg::PH_RX; // [RULE21]
                            end else begin
                                s_nxt.phase = pbcs_pkg::PH_CHECK; // [RULE1]
                            end
                        end else begin
                            s_nxt.set_cnt = s_r.set_cnt + 8'h01;
                        end
                    end
                end
                // checking: time each edge-to-edge interval
                pbcs_pkg::PH_CHECK: begin
                    if (low_fail || high_fail) begin
                        s_nxt.phase   = pbcs_pkg::PH_DORM; // [RULE4] [RULE11]
                        s_nxt.slp_cnt = '0;
                        s_nxt.opc.xtemp = 1'b0; // [RULE8]
                    end else if (edge_seen) begin
                        s_nxt.prev   = dm;
                        s_nxt.iv_cnt = '0; // [RULE20]
                        s_nxt.armed  = 1'b1;
                        if (s_r.armed) begin
                            s_nxt.chk_cnt = s_r.chk_cnt + 5'h01;
                            if (s_r.chk_cnt + 5'h01 == n_checks) begin
                                s_nxt.phase = pbcs_pkg::PH_RX; // [RULE17]
                            end
                        end
                    end else if (ext_tick) begin
                        s_nxt.iv_cnt = s_r.iv_cnt + 6'h01; // [RULE15]
                    end
                end
                // receiving: forward data until told to poll
                pbcs_pkg::PH_RX: begin
                    if (ret_wr) begin
                        s_nxt.phase   = pbcs_pkg::PH_DORM; // [RULE19]
                        s_nxt.slp_cnt = '0;
                    end
                end
                default: begin
                    s_nxt.phase = pbcs_pkg::PH_DORM;
                end
            endcase
            // data pin idles high outside receiving
            s_nxt.data = (s_r.phase == pbcs_pkg::PH_RX) ? dm : 1'b1; // [RULE17]
            // software write wins over the self-clear
            if (opc_wr) begin
                s_nxt.opc.baud  = apb_req.pwdata[`PBCS_OPC_BAUD_POS +: 2];
                s_nxt.opc.nbit  = apb_req.pwdata[`PBCS_OPC_NBIT_POS +: 2];
                s_nxt.opc.sleep = apb_req.pwdata[`PBCS_OPC_SLEEP_POS +: 5];
                s_nxt.opc.xstd  = apb_req.pwdata[`PBCS_OPC_XSTD_POS];
                s_nxt.opc.xtemp = apb_req.pwdata[`PBCS_OPC_XTMP_POS];
            end
            if (lim_wr) begin
                s_nxt.lim.lim_min = apb_req.pwdata[`PBCS_LIM_MIN_POS +: 6];
                s_nxt.lim.lim_max = apb_req.pwdata[`PBCS_LIM_MAX_POS +: 6];
            end
            // read data prepared in the setup cycle
            if (rd_setup) begin
                s_nxt.rdata = 32'h00000000;
                case (apb_req.paddr)
                    `PBCS_OFF_OPC: begin
                        s_nxt.rdata[`PBCS_OPC_BAUD_POS +: 2]  = s_r.opc.baud;
                        s_nxt.rdata[`PBCS_OPC_NBIT_POS +: 2]  = s_r.opc.nbit;
                        s_nxt.rdata[`PBCS_OPC_SLEEP_POS +: 5] = s_r.opc.sleep;
                        s_nxt.rdata[`PBCS_OPC_XSTD_POS]       = s_r.opc.xstd;
                        s_nxt.rdata[`PBCS_OPC_XTMP_POS]       = s_r.opc.xtemp;
                    end
                    `PBCS_OFF_LIM: begin
                        s_nxt.rdata[`PBCS_LIM_MIN_POS +: 6] = s_r.lim.lim_min;
                        s_nxt.rdata[`PBCS_LIM_MAX_POS +: 6] = s_r.lim.lim_max;
                    end
                    `PBCS_OFF_STAT: begin
                        s_nxt.rdata[`PBCS_ST_PHASE_POS +: 2] = s_r.phase;
                        s_nxt.rdata[`PBCS_ST_XTMP_POS]       = s_r.opc.xtemp;
                        s_nxt.rdata[`PBCS_ST_CHK_POS +: 5]   = s_r.chk_cnt;
                    end
                    default: begin
                        s_nxt.rdata = 32'h00000000;
                    end
                endcase
            end
        end
    end

    // state register with documented reset values
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r             <= '0;
            s_r.phase       <= pbcs_pkg::PH_DORM;
            s_r.opc.baud    <= `PBCS_RST_BAUD;
            s_r.opc.nbit    <= `PBCS_RST_NBIT;
            s_r.opc.sleep   <= `PBCS_RST_SLEEP;
            s_r.lim.lim_min <= `PBCS_RST_LIM_MIN; // [RULE14]
            s_r.lim.lim_max <= `PBCS_RST_LIM_MAX; // [RULE14]
            s_r.data        <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // checks of the sequencing
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    AST_DORM_QUIET: assert property ( // [RULE2]
        (s_r.phase == pbcs_pkg::PH_DORM) |-> !sig_proc_en
    ) else $error("processing enabled while dormant");

    AST_SETTLE_ON: assert property ( // [RULE3]
        (s_r.phase == pbcs_pkg::PH_SETTLE) |-> sig_proc_en
    ) else $error("processing off while settling");

    AST_CHECK_AFTER_SETTLE: assert property ( // [RULE1]
        ($changed(s_r.phase) && s_r.phase == pbcs_pkg::PH_CHECK)
        |-> ($past(s_r.phase) == pbcs_pkg::PH_SETTLE)
    ) else $error("checking not entered from settling");

    AST_SETTLE_AFTER_DORM: assert property ( // [RULE5]
        ($past(s_r.phase) == pbcs_pkg::PH_DORM && s_r.phase == pbcs_pkg::PH_SETTLE)
        |-> ($past(s_r.slp_cnt) >= $past(slp_target))
    ) else $error("dormant period cut short");

    AST_LOW_EDGE_FAIL: assert property ( // [RULE16]
        (clk_en && s_r.phase == pbcs_pkg::PH_CHECK && edge_seen && s_r.armed
         && (s_r.iv_cnt + 6'h01) < s_r.lim.lim_min)
        |=> (s_r.phase == pbcs_pkg::PH_DORM)
    ) else $error("early edge did not abort check");

    AST_UPPER_TIMEOUT: assert property ( // [RULE11]
        (clk_en && s_r.phase == pbcs_pkg::PH_CHECK && ext_tick && !edge_seen
         && s_r.iv_cnt + 6'h01 >= s_r.lim.lim_max)
        |=> (s_r.phase == pbcs_pkg::PH_DORM)
    ) else $error("interval reached upper count without abort");

    AST_PERMANENT_DORM: assert property ( // [RULE9]
        (s_r.phase == pbcs_pkg::PH_DORM && s_r.opc.sleep == `PBCS_SLEEP_PERM)
        |=> (s_r.phase == pbcs_pkg::PH_DORM)
    ) else $error("left permanent dormancy");

    AST_TEMP_CLEARS: assert property ( // [RULE8]
        ($past(s_r.phase) == pbcs_pkg::PH_CHECK && s_r.phase == pbcs_pkg::PH_DORM
         && !$past(opc_wr))
        |-> !s_r.opc.xtemp
    ) else $error("temporary stretch survived a failed check");

    AST_RX_HOLDS: assert property ( // [RULE19]
        (s_r.phase == pbcs_pkg::PH_RX && !ret_wr)
        |=> (s_r.phase == pbcs_pkg::PH_RX)
    ) else $error("receiving left without software request");

    AST_DATA_FWD: assert property ( // [RULE17]
        (clk_en && s_r.phase == pbcs_pkg::PH_RX) |=> (data_out == $past(dm))
    ) else $error("data not forwarded in receiving");

    AST_ZERO_BITS: assert property ( // [RULE21]
        ($past(s_r.phase) == pbcs_pkg::PH_SETTLE && s_r.phase != pbcs_pkg::PH_SETTLE
         && $past(s_r.opc.nbit) == 2'h0)
        |-> (s_r.phase == pbcs_pkg::PH_RX)
    ) else $error("zero bit count did not go to receiving");

    AST_PASS_COUNT: assert property ( // [RULE10]
        ($past(s_r.phase) == pbcs_pkg::PH_CHECK && s_r.phase == pbcs_pkg::PH_RX)
        |-> (s_r.chk_cnt == n_checks)
    ) else $error("receiving entered with wrong check count");

    AST_LOWER_BOUND_PASSES: assert property ( // [RULE12]
        (s_r.phase == pbcs_pkg::PH_CHECK && edge_seen && s_r.armed
         && (s_r.iv_cnt + 6'h01) == s_r.lim.lim_min)
        |=> (s_r.phase != pbcs_pkg::PH_DORM)
    ) else $error("interval equal to lower count was refused");

    AST_IV_ON_TICK: assert property ( // [RULE15]
        (s_r.phase == pbcs_pkg::PH_CHECK && !ext_tick) |=> $stable(s_r.iv_cnt)
    ) else $error("interval counter moved between extended ticks");

    // main scenarios
    COV_RX_ENTRY: cover property (
        s_r.phase == pbcs_pkg::PH_CHECK ##1 s_r.phase == pbcs_pkg::PH_RX
    );
    COV_LOW_FAIL: cover property (
        clk_en && s_r.phase == pbcs_pkg::PH_CHECK && low_fail
    );
    COV_HIGH_FAIL: cover property (
        clk_en && s_r.phase == pbcs_pkg::PH_CHECK && high_fail
    );
    COV_RETURN: cover property (
        s_r.phase == pbcs_pkg::PH_RX ##1 s_r.phase == pbcs_pkg::PH_DORM
    );

    COV_TEMP_CLEAR: cover property (
        s_r.opc.xtemp ##1 !s_r.opc.xtemp
    );
endmodule : pbcs_top

// ### test/pbcs_demod_model.sv
// Purpose: demodulator output model
// Assumes: gap is the edge spacing in clk cycles
// Notes: gap 0 holds the line steady, as with no carrier
`timescale 1ns/100ps
module pbcs_demod_model (
    input  wire logic       clk,
    input  wire logic [7:0] gap,
    output logic            demod
);
    logic [7:0] cnt = 8'h00;
    logic       lvl = 1'b0;
    // toggle the line every gap cycles
    always @(posedge clk) begin
        cnt <= (cnt + 8'h01 >= gap) ? 8'h00 : cnt + 8'h01;
        if (gap != 8'h00 && cnt + 8'h01 >= gap)
            lvl <= ~lvl;
    end
    assign demod = lvl;
endmodule : pbcs_demod_model

// ### test/tb.sv
// Purpose: self-checking bench of the sequencer
// Assumes: short counts, BASE_DIV 2 and SETTLE_XT 2
// Notes: read data checked from a queue by a bus monitor
`timescale 1ns/100ps
`include "pbcs_cfg.svh"
module tb;
    localparam int BD = 2;
    logic                    clk, reset_n, clk_en, demod, err;
    logic                    data_out, rx_active, sig_proc_en;
    logic [7:0]              gap;
    logic [31:0]             expq[$];
    pbcs_pkg::pbcs_apb_req_s req;
    pbcs_pkg::pbcs_apb_rsp_s rsp;
    int                      n_errors, comparisons, seed, t, e;

    pbcs_top #(.BASE_DIV(BD), .SETTLE_XT(2)) pbcs_top_inst (
        .clk(clk), .reset_n(reset_n), .clk_en(clk_en), .apb_req(req), .apb_rsp(rsp),
        .demod_in(demod), .data_out(data_out), .rx_active(rx_active),
        .sig_proc_en(sig_proc_en));
    pbcs_demod_model pbcs_demod_model_inst (.clk(clk), .gap(gap), .demod(demod));

    // free-running clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // take the oldest read note at each completed read
    always @(posedge clk) begin
        if (req.psel && req.penable && rsp.pready && !req.pwrite && expq.size() > 0)
            check(rsp.prdata, expq.pop_front());
    end

    // one transfer, held until pready is sampled high
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                       input logic [31:0] x);
        @(posedge clk);
        if (!w)
            expq.push_back(x);
        req <= '{a, w, d, 1'b1, 1'b0};
        @(posedge clk);
        req.penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (rsp.pready !== 1'b1);
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb

    // count cycles until rx_active or sig_proc_en shows level l
    task automatic wait_for(input logic rx, input logic l, input int lim);
        t = 0;
        while ((rx ? rx_active : sig_proc_en) !== l && t < lim) begin
            @(posedge clk);
            t++;
        end
        check(32'(rx ? rx_active : sig_proc_en), 32'(l));
    endtask : wait_for

    function automatic logic [31:0] opc(input logic [1:0] b, input logic [1:0] n,
                                        input logic [4:0] s, input logic xs, input logic xt);
        return {21'h000000, xt, xs, s, n, b};
    endfunction : opc

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    // watchdog against a hung sequence
    initial begin
        #800000;
        n_errors++;
        print_verdict();
    end

    initial begin
        seed = 32'hAE88933C;
        n_errors = 0;
        comparisons = 0;
        reset_n = 1'b0;
        clk_en = 1'b1;
        gap = 8'h00;
        req = '0;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        // defaults, window counts at the software bounds, unmapped read
        apb(`PBCS_OFF_OPC, 1'b0, 32'h0, 32'h000000B8);
        apb(`PBCS_OFF_LIM, 1'b0, 32'h0, 32'h0000180E);
        apb(`PBCS_OFF_LIM, 1'b1, 32'h00003F0A, 32'h0);
        apb(`PBCS_OFF_LIM, 1'b0, 32'h0, 32'h00003F0A);
        apb(`PBCS_OFF_LIM, 1'b1, 32'h0000180E, 32'h0);
        apb(12'h010, 1'b0, 32'h0, 32'h0);
        check(32'(err), 32'h1);
        $display("test registers done");
        // active span is settling plus the upper timeout, then a plain dormant span
        for (int b = 0; b < 4; b++) begin
            apb(`PBCS_OFF_OPC, 1'b1, opc(b[1:0], 2'h1, 5'h01, 1'b0, 1'b0), 32'h0);
            wait_for(1'b0, 1'b0, 40000);
            wait_for(1'b0, 1'b1, 40000);
            wait_for(1'b0, 1'b0, 20000);
            e = (8 >> b) * BD;
            check(32'(t >= 24 * e && t <= 28 * e), 32'h1);
            wait_for(1'b0, 1'b1, 40000);
            check(32'(t >= 2040 && t <= 2056), 32'h1);
        end
        $display("test bands done");
        // persistent stretch lengthens the next dormant span eightfold
        apb(`PBCS_OFF_OPC, 1'b1, opc(2'h3, 2'h1, 5'h01, 1'b1, 1'b0), 32'h0);
        wait_for(1'b0, 1'b0, 1000);
        wait_for(1'b0, 1'b1, 40000);
        check(32'(t >= 16376 && t <= 16400), 32'h1);
        // temporary stretch clears on an interval one below the lower count
        gap <= 8'h1A;
        apb(`PBCS_OFF_OPC, 1'b1, opc(2'h3, 2'h1, 5'h01, 1'b0, 1'b1), 32'h0);
        wait_for(1'b0, 1'b0, 1000);
        apb(`PBCS_OFF_OPC, 1'b0, 32'h0, opc(2'h3, 2'h1, 5'h01, 1'b0, 1'b0));
        wait_for(1'b0, 1'b1, 40000);
        check(32'(t >= 2040 && t <= 2056 && rx_active === 1'b0), 32'h1);
        $display("test stretch done");
        // each bit count, intervals at both window edges and random inside
        for (int n = 0; n < 4; n++) begin
            wait_for(1'b0, 1'b0, 1000);
            e = (n == 2) ? 14 : (n == 3) ? 23 : 14 + ($unsigned($random(seed)) % 10);
            gap <= 8'(2 * e);
            apb(`PBCS_OFF_OPC, 1'b1, opc(2'h3, n[1:0], 5'h01, 1'b0, 1'b0), 32'h0);
            wait_for(1'b0, 1'b1, 40000);
            wait_for(1'b1, 1'b1, 4000);
            check(32'(t >= 12 * n * e && t <= 12 * n * e + 2 * e + 16), 32'h1);
            gap <= 8'h00;
            repeat (5) @(posedge clk);
            check(32'(data_out), 32'(demod));
            repeat (300) @(posedge clk);
            check(32'(rx_active), 32'h1);
            apb(`PBCS_OFF_CTRL, 1'b1, 32'h1, 32'h0);
            wait_for(1'b1, 1'b0, 20);
            check(32'(rx_active), 32'h0);
        end
        $display("test receive done");
        // highest dormant count holds the dormant phase until rewritten
        apb(`PBCS_OFF_OPC, 1'b1, opc(2'h3, 2'h1, 5'h1F, 1'b0, 1'b0), 32'h0);
        t = 0;
        repeat (6000) begin
            @(posedge clk);
            if (sig_proc_en !== 1'b0)
                t++;
        end
        check(32'(t), 32'h0);
        apb(`PBCS_OFF_OPC, 1'b1, opc(2'h3, 2'h1, 5'h01, 1'b0, 1'b0), 32'h0);
        wait_for(1'b0, 1'b1, 3000);
        check(32'(t < 3000), 32'h1);
        $display("test permanent dormancy done");
        print_verdict();
    end
endmodule : tb
